/* File: shared/mtd_pkg.sv */
// Purpose: constants and types for the move-instruction decoder and stack
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: module specifiers are this core's own choice of codes
package mtd_pkg;
  localparam int INSTR_W = 16;
  localparam int FMT_BIT = 15;
  localparam int SRC_LSB = 0;
  localparam int DST_LSB = 8;
  localparam int STK_DEPTH = 4;
  localparam logic [1:0] SP_RESET = 2'h3;
  localparam logic [3:0] MOD_PFX = 4'hb;
  localparam logic [3:0] MOD_STK = 4'hd;
  localparam logic [3:0] MOD_DPC = 4'he;
  localparam logic [3:0] MOD_DP = 4'hf;
  localparam logic [3:0] MOD_ACC = 4'h9;
  localparam logic [3:0] IDX_PUSH = 4'h0;
  localparam logic [3:0] IDX_POP = 4'h1;
  localparam logic [3:0] IDX_POPV = 4'h2;
  localparam logic [3:0] IDX_SP = 4'h1;
  localparam logic [3:0] IDX_DPC = 4'h4;
  localparam logic [1:0] MAP_HARVARD = 2'h0;
  localparam logic [1:0] MAP_DATA_IN_CODE = 2'h1;
  localparam logic [1:0] MAP_CODE_IN_DATA = 2'h2;
  localparam logic [15:0] UROM_BASE = 16'h8000;
  localparam int UROM_WORDS = 2048;
  localparam int PROG_WORDS = 1024;
  localparam int DEE_BYTES = 128;
  localparam int SRAM_BYTES = 64;
  localparam logic [15:0] DATA_IN_CODE_BASE = 16'h0a00;
  localparam logic [15:0] CODE_IN_DATA_BASE = 16'h8000;
  typedef enum logic [1:0] {ST_RUN, ST_PFX} mtd_state_type;
endpackage

/* File: hdl/mtd_core.sv */
// Purpose: single-cycle move decode, destination prefix, data pointers, 4-level stack
// Assumes: instruction valid every cycle; register modules outside act on the strobes
// Notes: the prefix instruction itself is the extra cycle before the prefixed move
`timescale 1ns/1ps
`default_nettype none
module mtd_core
  import mtd_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int NUM_DP = 3
)(
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [INSTR_W-1:0] instr, // fetched instruction word
  input wire logic [DATA_W-1:0] src_rd_data, // data from selected source register
  input wire logic [DATA_W-1:0] pc_next, // return address for calls
  input wire logic call_req, // call executes this cycle
  input wire logic ret_req, // return executes this cycle
  input wire logic irq_vector, // interrupt vectoring this cycle
  input wire logic iret_req, // interrupt return this cycle
  input wire logic [1:0] map_mode, // memory mapping mode
  input wire logic [15:0] code_addr, // code-space address to route
  input wire logic [15:0] data_addr, // data-space address to route
  output logic [3:0] dst_module, // decoded destination module
  output logic [6:0] dst_index, // full destination index
  output logic dst_we, // destination write strobe
  output logic [3:0] src_module, // decoded source module
  output logic [3:0] src_index, // decoded source index
  output logic src_re, // source read strobe
  output logic [DATA_W-1:0] move_data, // data moved this cycle
  output logic [DATA_W-1:0] stack_top, // value popped or returned
  output logic [1:0] stack_index_reg, // stack pointer
  output logic [15:0] dp0, // data pointer 0
  output logic [15:0] dp1, // data pointer 1
  output logic [15:0] dp2, // data pointer 2
  output logic code_sel_data, // code fetch hits data memory
  output logic data_sel_code // data access hits code memory
);
  typedef struct packed {
    mtd_state_type st;
    logic [3:0] destination_extension_reg;
    logic [3:0] dmod;
    logic [6:0] didx;
    logic dwe;
    logic [3:0] smod;
    logic [3:0] sidx;
    logic sre;
    logic [DATA_W-1:0] mdat;
    logic [DATA_W-1:0] top;
    logic [1:0] sp;
    logic [STK_DEPTH-1:0][DATA_W-1:0] stk;
    logic [NUM_DP-1:0][15:0] dp;
    logic [NUM_DP-1:0][1:0] dpmode;
    logic csd;
    logic dsc;
  } mtd_regs_type;

  mtd_regs_type r_q, r_d;
  logic is_imm, push_op, pop_op;
  logic [DATA_W-1:0] src_val;
  logic [3:0] dmod_w, smod_w, sidx_w;
  logic [2:0] dsub_w;
  logic [1:0] sp_inc;

  always_comb
  begin
    r_d = r_q;
    is_imm = ~instr[FMT_BIT];
    smod_w = instr[SRC_LSB +: 4];
    sidx_w = instr[SRC_LSB+4 +: 4];
    dmod_w = instr[DST_LSB +: 4];
    dsub_w = instr[DST_LSB+4 +: 3];
    src_val = is_imm ? {{(DATA_W-8){1'b0}}, instr[SRC_LSB +: 8]} : src_rd_data;
    sp_inc = r_q.sp + 2'h1;
    push_op = call_req | irq_vector |
      (dmod_w == MOD_STK && dsub_w == IDX_PUSH[2:0]);
    pop_op = ret_req | iret_req | (!is_imm && smod_w == MOD_STK &&
      (sidx_w == IDX_POP || sidx_w == IDX_POPV));
    r_d.dwe = 1'b0;
    r_d.sre = 1'b0;
    // every move completes here; no stage holds a later instruction
    r_d.smod = smod_w;
    r_d.sidx = sidx_w;
    r_d.sre = ~is_imm;
    r_d.mdat = src_val;
    if (dmod_w == MOD_PFX)
    begin
      r_d.destination_extension_reg = src_val[3:0];
      r_d.st = ST_PFX;
    end
    else
    begin
      r_d.dmod = dmod_w;
      r_d.didx = (r_q.st == ST_PFX) ? {r_q.destination_extension_reg, dsub_w} : {4'h0, dsub_w};
      r_d.dwe = 1'b1;
      r_d.st = ST_RUN;
      r_d.destination_extension_reg = 4'h0;
    end
    if (push_op)
    begin
      r_d.sp = sp_inc;
      r_d.stk[sp_inc] = (call_req | irq_vector) ? pc_next : src_val;
    end
    else if (pop_op)
    begin
      r_d.top = r_q.stk[r_q.sp];
      r_d.sp = r_q.sp - 2'h1;
    end
    for (int i = 0; i < NUM_DP; i++)
    begin
      // mode: bit1 decrement, bit0 stored but unused
      if (dmod_w == MOD_DPC && dsub_w == IDX_DPC[2:0] && r_q.st != ST_PFX)
        r_d.dpmode[i] = src_val[2*i +: 2];
      if (dmod_w == MOD_DP && dsub_w == 3'(i))
        r_d.dp[i] = src_val[15:0];
      else if (!is_imm && smod_w == MOD_DP && sidx_w == 4'(i))
        r_d.dp[i] = r_q.dpmode[i][1] ? r_q.dp[i] - 16'h1 : r_q.dp[i] + 16'h1;
    end
    r_d.csd = (map_mode == MAP_DATA_IN_CODE) && (code_addr >= DATA_IN_CODE_BASE)
      && (code_addr < UROM_BASE);
    r_d.dsc = (map_mode == MAP_CODE_IN_DATA) && (data_addr >= CODE_IN_DATA_BASE);
    if (map_mode == MAP_HARVARD)
    begin
      r_d.csd = 1'b0;
      r_d.dsc = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_q <= '0;
      r_q.st <= ST_RUN;
      r_q.sp <= SP_RESET;
    end
    else
      r_q <= r_d;
  end

  assign dst_module = r_q.dmod;
  assign dst_index = r_q.didx;
  assign dst_we = r_q.dwe;
  assign src_module = r_q.smod;
  assign src_index = r_q.sidx;
  assign src_re = r_q.sre;
  assign move_data = r_q.mdat;
  assign stack_top = r_q.top;
  assign stack_index_reg = r_q.sp;
  assign dp0 = r_q.dp[0];
  assign dp1 = r_q.dp[1];
  assign dp2 = r_q.dp[2];
  assign code_sel_data = r_q.csd;
  assign data_sel_code = r_q.dsc;

  // memory sizes are fixed by the package; the assertion below checks their values
  initial
  begin
    assert (UROM_WORDS == 2048 && PROG_WORDS == 1024 && DEE_BYTES == 128
      && SRAM_BYTES == 64 && STK_DEPTH == 4)
    else $error("memory sizes wrong");
  end

  sequence s_push;
    push_op;
  endsequence
  sequence s_pop;
    !push_op && pop_op;
  endsequence

  a_sp_reset: assert property (@(posedge clk) srst |=> r_q.sp == SP_RESET)
    else $error("sp not three after reset");
  a_push_order: assert property (@(posedge clk) disable iff (srst)
    s_push |=> r_q.sp == $past(r_q.sp) + 2'h1 && r_q.stk[r_q.sp] == $past(
    (call_req | irq_vector) ? pc_next : src_val))
    else $error("push order wrong");
  a_pop_order: assert property (@(posedge clk) disable iff (srst)
    s_pop |=> r_q.top == $past(r_q.stk[r_q.sp]) && r_q.sp == $past(r_q.sp) - 2'h1)
    else $error("pop order wrong");
  a_pfx_once: assert property (@(posedge clk) disable iff (srst)
    dmod_w == MOD_PFX ##1 dmod_w != MOD_PFX |=> r_q.dwe && r_q.didx[6:3] == $past(r_q.destination_extension_reg)
    ##1 (r_q.st == ST_RUN))
    else $error("prefix not applied once");
  a_pfx_cycle: assert property (@(posedge clk) disable iff (srst)
    dmod_w == MOD_PFX |=> !r_q.dwe)
    else $error("prefix cost wrong");
  a_src_imm: assert property (@(posedge clk) disable iff (srst)
    !instr[FMT_BIT] |=> r_q.mdat == DATA_W'($past(instr[7:0])) && !r_q.sre)
    else $error("immediate source wrong");
  a_dst_field: assert property (@(posedge clk) disable iff (srst)
    dmod_w != MOD_PFX |=> r_q.dmod == $past(instr[11:8]) && r_q.didx[2:0] ==
    $past(instr[14:12]))
    else $error("destination field wrong");
  a_harvard: assert property (@(posedge clk) disable iff (srst)
    map_mode == MAP_HARVARD |=> !r_q.csd && !r_q.dsc)
    else $error("harvard mode mixes spaces");
endmodule
`default_nettype wire

/* File: tb/mtd_core_tb.sv */
// Purpose: self-checking bench for the move decoder, prefix and stack
// Assumes: every output settles one edge after the instruction it answers
// Notes: each note waits one negedge in the pending slot before it is compared
`timescale 1ns/1ps
`default_nettype none
module mtd_core_tb;
  import mtd_pkg::*;
  typedef struct {logic cd; logic cs; logic we; logic [3:0] dm; logic [6:0] di;
    logic [15:0] md; logic [3:0] sm; logic [3:0] si; logic [1:0] sp; logic [15:0] top;
    logic csd; logic dsc; logic [2:0][15:0] dp;} mtd_note_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic [15:0] src_rd_data = 16'h0000;
  logic [15:0] pc_next = 16'h0000;
  logic call_req = 1'b0;
  logic ret_req = 1'b0;
  logic irq_vector = 1'b0;
  logic iret_req = 1'b0;
  logic [1:0] map_mode = 2'h0;
  logic [15:0] code_addr = 16'h0000;
  logic [15:0] data_addr = 16'h0000;
  logic [3:0] dst_module, src_module, src_index;
  logic [6:0] dst_index;
  logic dst_we, src_re, code_sel_data, data_sel_code;
  logic [15:0] move_data, stack_top;
  logic [1:0] stack_index_reg;
  logic [15:0] dp0, dp1, dp2;
  logic [2:0][15:0] dp_m = '0;
  logic [2:0][1:0] dpm_m = '0;
  logic [3:0] pfx_m = 4'h0;
  logic [1:0] sp_m = SP_RESET;
  logic [15:0] top_m = 16'h0000;
  logic [15:0] stk_m [4];
  mtd_note_type q[$];
  mtd_note_type p;
  logic have = 1'b0;
  int err_count = 0;
  int compares = 0;

  always #10 clk = ~clk;

  mtd_core dut (.clk(clk), .srst(srst), .instr(instr), .src_rd_data(src_rd_data),
    .pc_next(pc_next), .call_req(call_req), .ret_req(ret_req), .irq_vector(irq_vector),
    .iret_req(iret_req), .map_mode(map_mode), .code_addr(code_addr), .data_addr(data_addr),
    .dst_module(dst_module), .dst_index(dst_index), .dst_we(dst_we), .src_module(src_module),
    .src_index(src_index), .src_re(src_re), .move_data(move_data), .stack_top(stack_top),
    .stack_index_reg(stack_index_reg), .dp0(dp0), .dp1(dp1), .dp2(dp2),
    .code_sel_data(code_sel_data), .data_sel_code(data_sel_code));

  task automatic final_report;
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // plain moves only: stack, pointer and prefix modules stay out of random picks
  function automatic logic [15:0] rnd_move();
    return {1'($urandom), 3'($urandom), 4'($urandom_range(9, 0)), 4'($urandom),
      4'($urandom_range(9, 0))};
  endfunction

  task automatic step(input logic [15:0] i, input logic [3:0] ctl);
    mtd_note_type n;
    logic [15:0] r;
    logic [15:0] pc;
    logic [15:0] ca;
    logic [15:0] da;
    logic [1:0] mm;
    r = 16'($urandom);
    pc = 16'($urandom);
    ca = 16'($urandom);
    da = 16'($urandom);
    mm = 2'($urandom_range(2, 0));
    @(posedge clk);
    instr <= i;
    src_rd_data <= r;
    pc_next <= pc;
    {call_req, ret_req, irq_vector, iret_req} <= ctl;
    map_mode <= mm;
    code_addr <= ca;
    data_addr <= da;
    n.md = i[15] ? r : {8'h00, i[7:0]};
    n.cd = i[11:8] != MOD_PFX && !(i[15] && i[3:0] == MOD_STK);
    n.cs = i[15];
    n.we = i[11:8] != MOD_PFX;
    n.dm = i[11:8];
    n.di = {pfx_m, i[14:12]};
    n.sm = i[3:0];
    n.si = i[7:4];
    pfx_m = (i[11:8] == MOD_PFX) ? i[3:0] : 4'h0;
    if (ctl[3] || ctl[1] || (i[11:8] == MOD_STK && i[14:12] == 3'h0))
    begin
      sp_m = sp_m + 2'h1;
      stk_m[sp_m] = (ctl[3] || ctl[1]) ? pc : n.md;
    end
    else if (ctl[2] || ctl[0] || (i[15] && i[3:0] == MOD_STK))
    begin
      top_m = stk_m[sp_m];
      sp_m = sp_m - 2'h1;
    end
    // step uses the mode held before this move, so it goes first
    for (int j = 0; j < 3; j++)
    begin
      if (i[11:8] == MOD_DP && i[14:12] == 3'(j))
        dp_m[j] = n.md;
      else if (i[15] && i[3:0] == MOD_DP && i[7:4] == 4'(j))
        dp_m[j] = dpm_m[j][1] ? dp_m[j] - 16'h1 : dp_m[j] + 16'h1;
      if (i[11:8] == MOD_DPC && i[14:12] == 3'h4)
        dpm_m[j] = n.md[2*j +: 2];
    end
    n.dp = dp_m;
    n.sp = sp_m;
    n.top = top_m;
    n.csd = mm == MAP_DATA_IN_CODE && ca >= DATA_IN_CODE_BASE && ca < CODE_IN_DATA_BASE;
    n.dsc = mm == MAP_CODE_IN_DATA && da >= CODE_IN_DATA_BASE;
    q.push_back(n);
  endtask

  task automatic check(input mtd_note_type n);
    if (n.cd)
    begin
      cmp(16'(dst_module), 16'(n.dm));
      cmp(16'(dst_index), 16'(n.di));
      cmp(move_data, n.md);
      cmp(16'(src_re), 16'(n.cs));
    end
    if (n.cd || !n.we)
      cmp(16'(dst_we), 16'(n.we));
    if (n.cd && n.cs)
    begin
      cmp(16'(src_module), 16'(n.sm));
      cmp(16'(src_index), 16'(n.si));
    end
    cmp(16'(stack_index_reg), 16'(n.sp));
    cmp(stack_top, n.top);
    cmp(16'(code_sel_data), 16'(n.csd));
    cmp(16'(data_sel_code), 16'(n.dsc));
    cmp(dp0, n.dp[0]);
    cmp(dp1, n.dp[1]);
    cmp(dp2, n.dp[2]);
  endtask

  always @(negedge clk)
  begin
    if (have)
      check(p);
    have = q.size() > 0;
    if (have)
      p = q.pop_front();
  end

  initial
  begin
    #100000;
    err_count++;
    final_report();
  end

  initial
  begin
    void'($urandom(32'he77160c8));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 24; k++)
      step(rnd_move(), 4'h0);
    for (int v = 1; v < 16; v += 5)
    begin
      step({1'b0, 3'h0, MOD_PFX, 8'(v)}, 4'h0);
      step(rnd_move(), 4'h0);
      step(rnd_move(), 4'h0);
    end
    // five pushes then five pops, so the pointer wraps both ways
    for (int k = 0; k < 5; k++)
      step(k[0] ? rnd_move() : {1'b0, 3'h0, MOD_STK, 8'($urandom)},
        k == 1 ? 4'h8 : (k == 3 ? 4'h2 : 4'h0));
    for (int k = 0; k < 5; k++)
      step((k == 2 || k == 3) ? rnd_move() : {1'b1, 7'h00, (k == 1 ? IDX_POPV : IDX_POP), MOD_STK},
        k == 2 ? 4'h4 : (k == 3 ? 4'h1 : 4'h0));
    for (int j = 0; j < 3; j++)
      step({1'b0, 3'(j), MOD_DP, 8'($urandom)}, 4'h0);
    // pointer 1 counts down, pointers 0 and 2 count up
    step({1'b0, 3'h4, MOD_DPC, 8'h08}, 4'h0);
    for (int j = 0; j < 6; j++)
      step({1'b1, 3'h0, 4'h0, 4'(j / 2), MOD_DP}, 4'h0);
    step(rnd_move(), 4'h0);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
